// File: rtl/flash_lock_and_page_addressing.sv
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "flash_lock_defs.svh"
module flash_lock_and_page_addressing
   import flash_lock_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire core_req_s   core_req,
   output core_rsp_s        core_rsp,
   input  wire ext_req_s    ext_req,
   output ext_rsp_s         ext_rsp,
   output logic             irq_block
);
   logic [5:0]  lock_q;
   logic [5:0]  lock_d;
   logic [2:0]  cfg_q;
   logic [2:0]  cfg_d;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   core_rsp_s   rsp_d;
   ext_rsp_s    ext_d;
   logic        irq_d;
   logic [31:0] rd_d;

   // Bus decode
   wire        addr_ok   = hsel & htrans[1] & hready;
   wire        rd_take   = addr_ok & ~hwrite;
   wire        wr_take   = addr_ok & hwrite;
   wire        wr_lock   = wr_pend_q & (wr_addr_q == `OFS_LOCK);
   wire        wr_cmd    = wr_pend_q & (wr_addr_q == `OFS_CMD);
   wire        wr_cfg    = wr_pend_q & (wr_addr_q == `OFS_CFG);
   wire        bus_erase = wr_cmd & hwdata[`CMD_ERASE_BIT];
   wire        ext_erase = ext_req.valid & (ext_req.op == EXT_ERASE);
   wire [7:0]  lock_byte = {`LOCK_UNUSED, lock_q};

   // Lock pairs
   wire boot_lock_high   = lock_q[5];
   wire boot_lock_low    = lock_q[4];
   wire app_lock_high    = lock_q[3];
   wire app_lock_low     = lock_q[2];
   wire memory_lock_high = lock_q[1];
   wire memory_lock_low  = lock_q[0];

   // Pointer mapping; top three pointer bits never reach the flash
   wire [6:0] page_number_field = core_req.ptr[12:6];
   wire [4:0] word_in_page_field = core_req.ptr[5:1];
   wire       byte_sel = core_req.ptr[0];
   wire [6:0] pc_page = core_req.pc[11:5];

   // Boot boundary from configured boot size
   wire [6:0] boot_page =
      (cfg_q[1:0] == 2'h0) ? `BOOT_PAGE_1024 :
      (cfg_q[1:0] == 2'h1) ? `BOOT_PAGE_512 :
      (cfg_q[1:0] == 2'h2) ? `BOOT_PAGE_256 : `BOOT_PAGE_128;
   wire tgt_boot = (page_number_field >= boot_page);
   wire pc_boot  = (pc_page >= boot_page);
   wire in_rww   = (page_number_field < `RWW_PAGES);
   wire ivsel    = cfg_q[`CFG_IVSEL_BIT];

   // Self-program write guard per section
   wire app_wr_ok  = app_lock_low;
   wire boot_wr_ok = boot_lock_low;
   wire sect_wr_ok = tgt_boot ? boot_wr_ok : app_wr_ok;

   // Loads across sections; same-section loads are never blocked
   wire app_rd_ok  = ~pc_boot | app_lock_high;
   wire boot_rd_ok = pc_boot | boot_lock_high;
   wire load_ok    = tgt_boot ? boot_rd_ok : app_rd_ok;

   wire spm_ptr_ok = ~byte_sel;
   wire wr_ptr_ok  = spm_ptr_ok & (word_in_page_field == 5'h00);

   logic core_allow;
   always_comb begin
      case (core_req.op)
         OP_LOAD:  core_allow = load_ok;
         OP_FILL:  core_allow = spm_ptr_ok;
         OP_ERASE: core_allow = spm_ptr_ok & sect_wr_ok;
         OP_WRITE: core_allow = wr_ptr_ok & sect_wr_ok;
         default:  core_allow = 1'b0;
      endcase
   end

   // External programming checks
   wire prog_ok   = memory_lock_low;
   wire verify_ok = memory_lock_high | memory_lock_low;
   logic ext_allow;
   always_comb begin
      case (ext_req.op)
         EXT_PROG:   ext_allow = prog_ok;
         EXT_VERIFY: ext_allow = verify_ok;
         EXT_FUSE:   ext_allow = prog_ok;
         EXT_ERASE:  ext_allow = 1'b1;
         default:    ext_allow = 1'b0;
      endcase
   end

   // Interrupts masked when the vectors sit in the other section and the running section is read-locked
   wire irq_app  = ~app_lock_high & ivsel & ~pc_boot;
   wire irq_boot = ~boot_lock_high & ~ivsel & pc_boot;

   always_comb begin
      rsp_d         = core_rsp;
      rsp_d.valid   = core_req.valid;
      if (core_req.valid) begin
         rsp_d.allow   = core_allow;
         rsp_d.in_rww  = in_rww;
         rsp_d.byte_hi = byte_sel;
         rsp_d.page    = page_number_field;
         rsp_d.word    = word_in_page_field;
      end
   end

   always_comb begin
      ext_d.valid = ext_req.valid;
      ext_d.allow = ext_req.valid ? ext_allow : ext_rsp.allow;
   end

   assign irq_d = irq_app | irq_boot;

   // Writes may only program bits; erase wins over a same-cycle program
   always_comb begin
      lock_d = lock_q;
      if (bus_erase | ext_erase) begin
         lock_d = `LOCK_RESET;
      end else if (wr_lock) begin
         lock_d = lock_q & hwdata[5:0];
      end
   end

   assign cfg_d = wr_cfg ? hwdata[2:0] : cfg_q;

   always_comb begin
      case (haddr)
         `OFS_LOCK:   rd_d = {24'h000000, lock_byte};
         `OFS_CFG:    rd_d = {29'h00000000, cfg_q};
         `OFS_STATUS: rd_d = {17'h00000, core_rsp.allow, core_rsp.in_rww,
                              core_rsp.byte_hi, core_rsp.page, core_rsp.word};
         default:     rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_q <= `LOCK_RESET;
         cfg_q  <= `CFG_RESET;
      end else begin
         lock_q <= lock_d;
         cfg_q  <= cfg_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= wr_take;
         wr_addr_q <= wr_take ? haddr : wr_addr_q;
         hrdata    <= rd_take ? rd_d : hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_rsp  <= '0;
         ext_rsp   <= '0;
         irq_block <= 1'b0;
      end else begin
         core_rsp  <= rsp_d;
         ext_rsp   <= ext_d;
         irq_block <= irq_d;
      end
   end
endmodule : flash_lock_and_page_addressing

// File: rtl/flash_lock_defs.svh
`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH
// Contract
// - Flash splits into 96 read-while-write pages then 32 no-read-while-write pages.
// - Program counter is 12 bits, top bit 11, addressing 16-bit words.
// - A page holds 32 words selected by program counter bits 4..0.
// - Erase and write take the page number from pointer bits 12..6.
// - Buffer fill word index is pointer bits 5..1; zero for page write.
// - Pointer bits 15..13 are ignored for all flash addressing.
// - Pointer bit 0 is zero for self-program, byte select for loads.
// - Six lock bits, one unprogrammed, zero programmed, all default to one.
// - Only chip erase returns lock bits to one; hresetn also reloads them to one here.
// - Lock byte: 7..6 read one, 5..4 boot, 3..2 application, 1..0 memory.
// - Memory mode 1 puts no restriction on external programming.
// - Memory mode 2 refuses external programming and locks the fuses.
// - Memory mode 3 also refuses external read-back verification.
// - Application pair all ones leaves application accesses unrestricted.
// - Application modes 2 and 3 block self-program writes to application.
// - Application modes 3 and 4 block boot-side loads of application.
// - Application modes 3 and 4 with boot vectors mask interrupts in application.
// - Boot pair all ones leaves boot accesses unrestricted.
// - Boot modes 2 and 3 block self-program writes to boot.
// - Boot modes 3 and 4 block application-side loads of boot.
// - Boot modes 3 and 4 with application vectors mask interrupts in boot.
`define OFS_LOCK        8'h00
`define OFS_CMD         8'h04
`define OFS_CFG         8'h08
`define OFS_STATUS      8'h0c
`define CMD_ERASE_BIT   0
`define CFG_IVSEL_BIT   2
`define LOCK_RESET      6'h3f
`define LOCK_UNUSED     2'h3
`define CFG_RESET       3'h0
`define RWW_PAGES       7'h60
`define BOOT_PAGE_1024  7'h60
`define BOOT_PAGE_512   7'h70
`define BOOT_PAGE_256   7'h78
`define BOOT_PAGE_128   7'h7c
`endif

// File: rtl/flash_lock_pkg.sv
package flash_lock_pkg;
   typedef enum logic [1:0] {
      OP_LOAD  = 2'h0,
      OP_FILL  = 2'h1,
      OP_ERASE = 2'h2,
      OP_WRITE = 2'h3
   } core_op_e;
   typedef enum logic [1:0] {
      EXT_PROG   = 2'h0,
      EXT_VERIFY = 2'h1,
      EXT_FUSE   = 2'h2,
      EXT_ERASE  = 2'h3
   } ext_op_e;
   typedef struct packed {
      logic        valid;
      core_op_e    op;
      logic [15:0] ptr;
      logic [11:0] pc;
   } core_req_s;
   typedef struct packed {
      logic        valid;
      logic        allow;
      logic        in_rww;
      logic        byte_hi;
      logic [6:0]  page;
      logic [4:0]  word;
   } core_rsp_s;
   typedef struct packed {
      logic    valid;
      ext_op_e op;
   } ext_req_s;
   typedef struct packed {
      logic valid;
      logic allow;
   } ext_rsp_s;
endpackage : flash_lock_pkg

// File: verif/flash_lock_and_page_addressing_bench.sv
`timescale 1ns/1ps
module flash_lock_and_page_addressing_bench
   import flash_lock_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_block;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   core_req_s   core_req;
   core_rsp_s   core_rsp;
   ext_req_s    ext_req;
   ext_rsp_s    ext_rsp;
   int          mismatches = 0;
   int          tests_run = 0;
   flash_lock_and_page_addressing flash_lock_and_page_addressing_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_req(core_req), .core_rsp(core_rsp),
      .ext_req(ext_req), .ext_rsp(ext_rsp), .irq_block(irq_block));
   flash_lock_partner flash_lock_partner_inst (.hclk(hclk), .core_req(core_req),
      .ext_req(ext_req));
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // Read data is taken at the edge that closes the data phase
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      if (!w) chk(hrdata, e);
      chk({31'h00000000, hresp}, 32'h00000000);
   endtask : bus
   task core(input core_op_e op, input logic [15:0] p, input logic [11:0] pc, input logic a);
      flash_lock_partner_inst.core_go(op, p, pc);
      #1;
      chk(core_rsp.valid, 1'b1);
      chk(core_rsp.allow, a);
   endtask : core
   task ext(input ext_op_e op, input logic a);
      flash_lock_partner_inst.ext_go(op);
      #1;
      chk(ext_rsp.allow, a);
   endtask : ext
   task irq(input logic e);
      repeat (2) @(posedge hclk);
      #1;
      chk(irq_block, e);
   endtask : irq
   task results();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      #20000;
      mismatches++;
      results();
   end
   initial begin
      {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h00, 0, 32'hff);
      bus(1'b1, 8'h00, 32'hfe, 0);
      bus(1'b0, 8'h00, 0, 32'hfe);
      bus(1'b1, 8'h00, 32'hff, 0);
      bus(1'b0, 8'h00, 0, 32'hfe);
      ext(EXT_PROG, 1'b0);
      ext(EXT_FUSE, 1'b0);
      ext(EXT_VERIFY, 1'b1);
      bus(1'b1, 8'h00, 32'hfc, 0);
      ext(EXT_VERIFY, 1'b0);
      ext(EXT_ERASE, 1'b1);
      bus(1'b0, 8'h00, 0, 32'hff);
      ext(EXT_PROG, 1'b1);
      $display("test external done");
      core(OP_FILL, 16'h0401, 12'h100, 1'b0);
      core(OP_WRITE, 16'h0402, 12'h100, 1'b0);
      core(OP_WRITE, 16'he400, 12'h100, 1'b1);
      core(OP_LOAD, 16'h1c01, 12'h100, 1'b1);
      bus(1'b1, 8'h00, 32'hfb, 0);
      core(OP_ERASE, 16'he400, 12'he00, 1'b0);
      core(OP_ERASE, 16'h1c00, 12'he00, 1'b1);
      core(OP_LOAD, 16'h0400, 12'he00, 1'b1);
      bus(1'b1, 8'h00, 32'hf3, 0);
      core(OP_LOAD, 16'h0400, 12'he00, 1'b0);
      core(OP_LOAD, 16'h0400, 12'h100, 1'b1);
      bus(1'b1, 8'h08, 32'h4, 0);
      irq(1'b1);
      bus(1'b1, 8'h04, 32'h1, 0);
      bus(1'b0, 8'h00, 0, 32'hff);
      irq(1'b0);
      $display("test application lock done");
      bus(1'b1, 8'h00, 32'hcf, 0);
      core(OP_WRITE, 16'h1c00, 12'he00, 1'b0);
      core(OP_LOAD, 16'h1c00, 12'h100, 1'b0);
      bus(1'b1, 8'h08, 32'h0, 0);
      core(OP_LOAD, 16'h0400, 12'he00, 1'b1);
      irq(1'b1);
      bus(1'b1, 8'h08, 32'h3, 0);
      core(OP_ERASE, 16'h1c00, 12'he00, 1'b1);
      bus(1'b0, 8'h0c, 0, 32'h4e00);
      bus(1'b0, 8'h20, 0, 32'h0);
      $display("test boot lock done");
      results();
   end
endmodule : flash_lock_and_page_addressing_bench

// File: verif/flash_lock_assertions.sv
`timescale 1ns/1ps
module flash_lock_assertions
   import flash_lock_pkg::*;
(
   input wire logic      hclk,
   input wire logic      hresetn,
   input wire core_req_s core_req,
   input wire core_rsp_s core_rsp,
   input wire ext_req_s  ext_req,
   input wire ext_rsp_s  ext_rsp
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_pulse; core_rsp.valid == $past(core_req.valid); endproperty
   a_pulse: assert property (p_pulse) else $error("core answer pulse");
   property p_page; core_req.valid |=> core_rsp.page == $past(core_req.ptr[12:6])
      && core_rsp.word == $past(core_req.ptr[5:1]); endproperty
   a_page: assert property (p_page) else $error("page or word field");
   property p_byte; core_req.valid |=> core_rsp.byte_hi == $past(core_req.ptr[0]); endproperty
   a_byte: assert property (p_byte) else $error("byte select");
   property p_rww; core_req.valid |=> core_rsp.in_rww == ($past(core_req.ptr[12:6]) < 7'h60);
   endproperty
   a_rww: assert property (p_rww) else $error("region flag");
   property p_odd; core_req.valid && core_req.op != OP_LOAD && core_req.ptr[0]
      |=> !core_rsp.allow; endproperty
   a_odd: assert property (p_odd) else $error("odd pointer allowed");
   property p_wword; core_req.valid && core_req.op == OP_WRITE && core_req.ptr[5:1] != 5'h0
      |=> !core_rsp.allow; endproperty
   a_wword: assert property (p_wword) else $error("page write word not zero");
   property p_ext; ext_req.valid |=> ext_rsp.valid; endproperty
   a_ext: assert property (p_ext) else $error("external answer missing");
   property p_erase; ext_req.valid && ext_req.op == EXT_ERASE |=> ext_rsp.allow; endproperty
   a_erase: assert property (p_erase) else $error("chip erase refused");
endmodule : flash_lock_assertions
bind flash_lock_and_page_addressing flash_lock_assertions flash_lock_assertions_inst (
   .hclk(hclk), .hresetn(hresetn), .core_req(core_req), .core_rsp(core_rsp),
   .ext_req(ext_req), .ext_rsp(ext_rsp));

// File: verif/flash_lock_partner.sv
`timescale 1ns/1ps
module flash_lock_partner
   import flash_lock_pkg::*;
(
   input  wire logic hclk,
   output core_req_s core_req,
   output ext_req_s  ext_req
);
   initial begin
      core_req = '0;
      ext_req = '0;
   end
   // Pc stays put between requests, as a running program would hold it
   task core_go(input core_op_e op, input logic [15:0] p, input logic [11:0] pc);
      @(posedge hclk);
      core_req <= '{1'b1, op, p, pc};
      @(posedge hclk);
      core_req.valid <= 1'b0;
   endtask : core_go
   // Fuse writes are issued after a lock change in the session
   task ext_go(input ext_op_e op);
      @(posedge hclk);
      ext_req <= '{1'b1, op};
      @(posedge hclk);
      ext_req.valid <= 1'b0;
   endtask : ext_go
endmodule : flash_lock_partner
